// >>> fault_map.svh
// Timing counts and qualification counts for the fault sequencer
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH

`define CLK_FREQ_MHZ     250
`define POWER_TIME_MS    160
`define RECOVERY_TIME_MS 1500
`define POWER_CYCLES     (`POWER_TIME_MS * 1000 * `CLK_FREQ_MHZ)
`define RECOVERY_CYCLES  (`RECOVERY_TIME_MS * 1000 * `CLK_FREQ_MHZ)
`define OV_PULSES        3
`define OTP_PULSES       4
`define TEST_PULSES      3
`define CNT_W            4

`endif

// >>> fault_pkg.sv
// Types shared by the fault sequencer
package fault_pkg;
    typedef enum logic [1:0]
    {
        st_run      = 2'b00,
        st_recovery = 2'b01,
        st_wait_off = 2'b10,
        st_otp      = 2'b11
    } seq_state_type;
endpackage

// >>> pulse_qualifier.sv
// Consecutive-pulse fault qualifier
`timescale 1ns/10ps
`include "fault_map.svh"
module pulse_qualifier #(
    parameter int COUNT = 3
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Sampling
    input  wire logic sample,
    input  wire logic cond,
    // Result
    output logic      hit
);
    logic [`CNT_W-1:0] count;
    wire               at_limit;
    wire               next_hit;

    if (COUNT < 1 || COUNT > 15)
    begin : bad_count
        $error("pulse_qualifier COUNT out of range");
    end

    assign at_limit = (count == COUNT[`CNT_W-1:0] - 4'h1);
    assign next_hit = sample & cond & at_limit;

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            count <= 4'h0;
        else if (sample && !cond)
            count <= 4'h0;
        else if (sample && !at_limit)
            count <= count + 4'h1;
        else if (next_hit)
            count <= 4'h0;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            hit <= 1'b0;
        else
            hit <= next_hit;
    end

    miss_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample && !cond |=> count == 4'h0)
        else $error("qualifier count not cleared on miss");
endmodule

// >>> fault_sequencer.sv
// Fault-protection sequencer for an active-clamp flyback controller
// Overview of operation
// - Sample aux sense after low-side turn-off
// - Three over-voltage pulses stop, disable, start recovery
// - No low-side pulses during recovery delay
// - After delay, restart at next supply-off
// - Four cold-thermistor pulses latch fault, raise
// - Clear thermistor fault only above raised threshold
// - Grounded thermistor: three test pulses per cycle
// - Over-power timer starts when peak exceeds threshold
// - Continuous 160 ms over-power enters recovery
// - Over-power threshold at most 0.6 V
// - Peak sense never passes 0.8 V ceiling
// - No clamp pulses in low-power or standby
// - Clamp pulses enabled entering adaptive burst
`timescale 1ns/10ps
`include "fault_map.svh"
module fault_sequencer #(
    parameter int unsigned POWER_CYCLES    = `POWER_CYCLES,
    parameter int unsigned RECOVERY_CYCLES = `RECOVERY_CYCLES
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Modulator requests
    input  wire logic low_side_request,
    input  wire logic clamp_request,
    // Operating mode
    input  wire logic low_power_operation,
    input  wire logic standby_burst_operation,
    input  wire logic adaptive_burst_operation,
    // Analog comparators
    input  wire logic aux_winding_sense_input,
    input  wire logic thermistor_input,
    input  wire logic overpower_compare,
    input  wire logic peak_sense_ceiling,
    input  wire logic supply_lockout_cycle,
    // Power stage
    output logic      low_side_gate_pulse,
    output logic      clamp_gate_pulse,
    output logic      power_stage_enable,
    // Status
    output logic      output_overvoltage_fault,
    output logic      overpower_fault,
    output logic      overtemp_fault,
    output logic      thermistor_threshold_raise,
    output logic      fault_recovery_delay,
    output logic      startup_pulse
);
    logic [1:0]              ov_sync;
    logic [1:0]              therm_sync;
    logic [1:0]              power_sync;
    logic [1:0]              ceil_sync;
    logic [2:0]              off_sync;
    fault_pkg::seq_state_type state;
    fault_pkg::seq_state_type next_state;
    logic                    sample;
    logic                    ceiling_block;
    logic                    clamp_enable;
    logic                    burst_prev;
    logic [31:0]             power_count;
    logic [31:0]             recovery_count;
    logic [1:0]              test_left;
    logic                    ov_hit;
    logic                    otp_hit;

    wire ov_now       = ov_sync[1];
    wire therm_low    = therm_sync[1];
    wire power_now    = power_sync[1];
    wire ceil_now     = ceil_sync[1];
    wire supply_off   = off_sync[1] & ~off_sync[2];
    wire in_run       = (state == fault_pkg::st_run);
    wire in_otp       = (state == fault_pkg::st_otp);
    wire test_window  = in_otp & (test_left != 2'h0);
    wire allow_pulses = in_run | test_window;
    wire power_expire = in_run & power_now & (power_count == POWER_CYCLES - 1);
    wire recov_expire = (state == fault_pkg::st_recovery) & (recovery_count == 32'h0);
    wire otp_clear    = in_otp & sample & ~therm_low;
    wire next_low     = low_side_request & allow_pulses & ~ceiling_block & ~ceil_now
                        & ~(in_run & (ov_hit | power_expire | otp_hit));
    wire burst_entry  = adaptive_burst_operation & ~burst_prev;
    wire quiet_mode   = low_power_operation | standby_burst_operation;
    wire next_clamp   = clamp_request & clamp_enable & ~quiet_mode & in_run & ~low_side_gate_pulse;
    wire next_enable  = (next_state == fault_pkg::st_run) | (next_state == fault_pkg::st_otp);

    if (POWER_CYCLES < 2 || RECOVERY_CYCLES < 2)
    begin : bad_timer_counts
        $error("fault_sequencer timer counts too small");
    end

    // Comparator and supply synchronisers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ov_sync    <= 2'h0;
            therm_sync <= 2'h0;
            power_sync <= 2'h0;
            ceil_sync <= 2'h0;
            off_sync  <= 3'h0;
        end
        else
        begin
            ov_sync    <= {ov_sync[0], aux_winding_sense_input};
            therm_sync <= {therm_sync[0], thermistor_input};
            power_sync <= {power_sync[0], overpower_compare};
            ceil_sync <= {ceil_sync[0], peak_sense_ceiling};
            off_sync  <= {off_sync[1:0], supply_lockout_cycle};
        end
    end

    pulse_qualifier #(
        .COUNT (`OV_PULSES)
    ) ov_qual (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sample  (sample),
        .cond    (ov_now),
        .hit     (ov_hit)
    );

    pulse_qualifier #(
        .COUNT (`OTP_PULSES)
    ) otp_qual (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .sample  (sample & in_run),
        .cond    (therm_low),
        .hit     (otp_hit)
    );

    // Next sequencer state
    always_comb
    begin
        next_state = state;
        case (state)
            fault_pkg::st_run:
            begin
                if (ov_hit || power_expire)
                    next_state = fault_pkg::st_recovery;
                else if (otp_hit)
                    next_state = fault_pkg::st_otp;
            end
            fault_pkg::st_recovery:
            begin
                if (recov_expire)
                    next_state = fault_pkg::st_wait_off;
            end
            fault_pkg::st_wait_off:
            begin
                if (supply_off)
                    next_state = fault_pkg::st_run;
            end
            fault_pkg::st_otp:
            begin
                if (otp_clear)
                    next_state = fault_pkg::st_run;
            end
            default:
                next_state = fault_pkg::st_recovery;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            state <= fault_pkg::st_wait_off;
        else
            state <= next_state;
    end

    // Turn-off strobe and pulse-by-pulse ceiling
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sample        <= 1'b0;
            ceiling_block <= 1'b0;
        end
        else
        begin
            sample        <= low_side_gate_pulse & ~next_low;
            ceiling_block <= low_side_request & (ceiling_block | ceil_now);
        end
    end

    // Over-power timer, threshold is line-compensated in the analog path
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            power_count <= 32'h0;
        else if (!power_now || !in_run)
            power_count <= 32'h0;
        else if (!power_expire)
            power_count <= power_count + 32'h1;
    end

    // Recovery delay
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            recovery_count <= 32'h0;
        else if (in_run && next_state == fault_pkg::st_recovery)
            recovery_count <= RECOVERY_CYCLES - 1;
        else if (recovery_count != 32'h0)
            recovery_count <= recovery_count - 32'h1;
    end

    // Test pulses per supply cycle while the thermistor fault holds
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            test_left <= 2'h0;
        else if (in_otp && supply_off)
            test_left <= 2'(`TEST_PULSES);
        else if (sample && test_left != 2'h0)
            test_left <= test_left - 2'h1;
    end

    // Clamp enable by operating mode
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clamp_enable <= 1'b0;
            burst_prev   <= 1'b0;
        end
        else
        begin
            burst_prev <= adaptive_burst_operation;
            if (quiet_mode)
                clamp_enable <= 1'b0;
            else if (burst_entry)
                clamp_enable <= 1'b1;
        end
    end

    // Registered outputs
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_side_gate_pulse        <= 1'b0;
            clamp_gate_pulse           <= 1'b0;
            power_stage_enable         <= 1'b0;
            output_overvoltage_fault   <= 1'b0;
            overpower_fault            <= 1'b0;
            overtemp_fault             <= 1'b0;
            thermistor_threshold_raise <= 1'b0;
            fault_recovery_delay       <= 1'b0;
            startup_pulse              <= 1'b0;
        end
        else
        begin
            low_side_gate_pulse <= next_low;
            clamp_gate_pulse    <= next_clamp;
            power_stage_enable  <= next_enable;
            if (in_run && ov_hit)
                output_overvoltage_fault <= 1'b1;
            else if (next_state == fault_pkg::st_run && !in_run)
                output_overvoltage_fault <= 1'b0;
            if (power_expire && !ov_hit)
                overpower_fault <= 1'b1;
            else if (next_state == fault_pkg::st_run && !in_run)
                overpower_fault <= 1'b0;
            overtemp_fault             <= (next_state == fault_pkg::st_otp);
            thermistor_threshold_raise <= (next_state == fault_pkg::st_otp);
            fault_recovery_delay       <= (next_state == fault_pkg::st_recovery);
            startup_pulse              <= (state == fault_pkg::st_wait_off) & supply_off;
        end
    end

    no_recovery_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fault_recovery_delay |-> !low_side_gate_pulse)
        else $error("low-side pulse during recovery delay");

    ov_stop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_run && ov_hit |=> fault_recovery_delay && !power_stage_enable
        && !low_side_gate_pulse && output_overvoltage_fault)
        else $error("over-voltage did not stop the stage");

    ceiling_cut_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ceil_now && low_side_gate_pulse |=> !low_side_gate_pulse)
        else $error("low-side pulse not ended at ceiling");

    clamp_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        quiet_mode |=> !clamp_gate_pulse && !clamp_enable)
        else $error("clamp pulse in quiet mode");

    clamp_burst_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        burst_entry && !quiet_mode |=> clamp_enable)
        else $error("clamp not enabled on adaptive burst entry");

    power_timer_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !power_now |=> power_count == 32'h0)
        else $error("over-power timer not cleared");

    power_trip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        power_expire && !ov_hit |=> fault_recovery_delay && overpower_fault
        && recovery_count == RECOVERY_CYCLES - 1)
        else $error("over-power expiry did not start recovery");

    otp_raise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_run && otp_hit && !ov_hit && !power_expire |=> thermistor_threshold_raise
        && overtemp_fault)
        else $error("thermistor fault not latched");

    otp_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_otp && !(sample && !therm_low) |=> in_otp)
        else $error("thermistor fault cleared without release");

    restart_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state == fault_pkg::st_wait_off && supply_off |=> in_run && startup_pulse)
        else $error("no restart at supply turn-off");

    test_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        in_otp && supply_off |=> test_left == 2'(`TEST_PULSES))
        else $error("test pulses not armed");

    ov_trip_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        in_run && ov_hit ##[1:20] fault_recovery_delay);
    power_trip_c: cover property (@(posedge ref_clk) disable iff (!rst_n) power_expire);
    otp_cycle_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
        in_otp && otp_clear);
endmodule

// >>> power_stage_model.sv
// Behavioural flyback power stage and its sense comparators
`timescale 1ns/10ps
module power_stage_model (
    // Clock
    input  wire logic       ref_clk,
    // Controller side
    input  wire logic       gate,
    // Scenario levels
    input  wire logic       ov_level,
    input  wire logic       cold_level,
    input  wire logic       power_level,
    input  wire logic [7:0] ramp_limit,
    // Comparator results
    output logic            aux_sense,
    output logic            therm_cold,
    output logic            power_high,
    output logic            ceiling_hit
);
    logic [7:0] ramp;

    // Primary current ramps while the low-side switch is on
    always_ff @(posedge ref_clk)
        ramp <= gate ? ramp + 8'h01 : 8'h00;

    assign aux_sense   = ov_level;
    assign therm_cold  = cold_level;
    assign power_high  = power_level;
    assign ceiling_hit = gate & (ramp >= ramp_limit);
endmodule

// >>> tb_flyback_fault_protection_sequencer.sv
// Self-checking bench for the fault-protection sequencer
`timescale 1ns/10ps
module tb_flyback_fault_protection_sequencer;
    localparam int POWER_N = 50;
    localparam int RECOV_N = 100;
    logic       ref_clk;
    logic       rst_n;
    logic       req, clamp_req, lp, sb, ab, ov, cold, pwr, supply;
    logic [7:0] ramp_limit;
    logic       aux, therm, pwr_cmp, ceil;
    logic       gate, clamp, enable, ov_f, pwr_f, ot_f, raise, rec, start;
    int         miscompares, n_compared, gate_cnt, rec_cnt;

    fault_sequencer #(.POWER_CYCLES(POWER_N), .RECOVERY_CYCLES(RECOV_N)) dut (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .low_side_request(req), .clamp_request(clamp_req),
        .low_power_operation(lp), .standby_burst_operation(sb),
        .adaptive_burst_operation(ab),
        .aux_winding_sense_input(aux), .thermistor_input(therm),
        .overpower_compare(pwr_cmp), .peak_sense_ceiling(ceil),
        .supply_lockout_cycle(supply),
        .low_side_gate_pulse(gate), .clamp_gate_pulse(clamp),
        .power_stage_enable(enable), .output_overvoltage_fault(ov_f),
        .overpower_fault(pwr_f), .overtemp_fault(ot_f),
        .thermistor_threshold_raise(raise), .fault_recovery_delay(rec),
        .startup_pulse(start));

    power_stage_model power_stage (
        .ref_clk(ref_clk), .gate(gate), .ov_level(ov), .cold_level(cold),
        .power_level(pwr), .ramp_limit(ramp_limit), .aux_sense(aux),
        .therm_cold(therm), .power_high(pwr_cmp), .ceiling_hit(ceil));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        if (gate === 1'b1) gate_cnt++;
        if (rec === 1'b1) rec_cnt++;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic pulse(input int n);
        gate_cnt = 0;
        @(negedge ref_clk) req = 1'b1;
        repeat (n) @(negedge ref_clk);
        req = 1'b0;
        repeat (6) @(negedge ref_clk);
    endtask

    task automatic supply_off(output logic started);
        started = 1'b0;
        @(negedge ref_clk) supply = 1'b1;
        repeat (8) @(negedge ref_clk) if (start === 1'b1) started = 1'b1;
        supply = 1'b0;
        repeat (4) @(negedge ref_clk);
    endtask

    task automatic wait_recovery_end;
        int i;
        for (i = 0; i < 400 && rec === 1'b1; i++) @(negedge ref_clk);
        check("recovery_length", 32'(rec_cnt >= RECOV_N && rec_cnt <= RECOV_N + 1), 1);
    endtask

    task automatic mode(input logic l, input logic s, input logic a, input logic exp);
        @(negedge ref_clk) {lp, sb, ab} = {l, s, a};
        repeat (4) @(negedge ref_clk);
        check("clamp_gate", clamp, exp);
    endtask

    task automatic test_startup;
        logic s;
        pulse(4);
        check("gate_before_start", gate_cnt, 0);
        supply_off(s);
        check("startup_seen", s, 1);
        check("enable_run", enable, 1);
        pulse(4);
        check("gate_width", gate_cnt, 4);
        $display("test startup done");
    endtask

    task automatic test_clamp;
        clamp_req = 1'b1;
        mode(0, 0, 0, 0);
        mode(0, 0, 1, 1);
        mode(1, 0, 1, 0);
        mode(0, 0, 1, 0);
        mode(0, 0, 0, 0);
        mode(0, 0, 1, 1);
        mode(0, 1, 1, 0);
        mode(0, 0, 0, 0);
        clamp_req = 1'b0;
        $display("test clamp done");
    endtask

    task automatic test_ceiling;
        ramp_limit = 8'h04;
        pulse(20);
        check("ceiling_cut", 32'(gate_cnt >= 4 && gate_cnt <= 8), 1);
        ramp_limit = 8'hFF;
        pulse(20);
        check("no_ceiling", gate_cnt, 20);
        $display("test ceiling done");
    endtask

    task automatic test_ov;
        logic s;
        ov = 1'b1;
        repeat (2) pulse(4);
        ov = 1'b0;
        pulse(4);
        ov = 1'b1;
        repeat (2) pulse(4);
        check("ov_not_yet", ov_f, 0);
        rec_cnt = 0;
        pulse(4);
        check("ov_trip", {ov_f, enable, rec}, 3'b101);
        ov = 1'b0;
        pulse(4);
        check("gate_in_recovery", gate_cnt, 0);
        wait_recovery_end();
        pulse(4);
        check("gate_in_wait_off", gate_cnt, 0);
        supply_off(s);
        check("restart_after_ov", {s, enable, ov_f}, 3'b110);
        $display("test over-voltage done");
    endtask

    task automatic test_power;
        logic s;
        int   i;
        @(negedge ref_clk) pwr = 1'b1;
        repeat (30) @(negedge ref_clk);
        pwr = 1'b0;
        @(negedge ref_clk) pwr = 1'b1;
        repeat (30) @(negedge ref_clk);
        pwr = 1'b0;
        repeat (4) @(negedge ref_clk);
        check("power_interrupted", pwr_f, 0);
        rec_cnt = 0;
        pwr = 1'b1;
        for (i = 0; i < 80 && pwr_f !== 1'b1; i++) @(negedge ref_clk);
        pwr = 1'b0;
        check("power_delay", 32'(i >= POWER_N && i <= POWER_N + 6), 1);
        check("power_stop", {enable, rec}, 2'b01);
        wait_recovery_end();
        supply_off(s);
        check("restart_after_power", {s, pwr_f}, 2'b10);
        $display("test over-power done");
    endtask

    task automatic test_otp;
        logic s;
        cold = 1'b1;
        repeat (3) pulse(4);
        check("otp_not_yet", ot_f, 0);
        pulse(4);
        check("otp_trip", {ot_f, raise}, 2'b11);
        pulse(4);
        check("gate_in_otp", gate_cnt, 0);
        supply_off(s);
        repeat (3)
        begin
            pulse(4);
            check("test_pulse", gate_cnt, 4);
        end
        check("otp_held", ot_f, 1);
        cold = 1'b0;
        supply_off(s);
        pulse(4);
        check("otp_clear", {ot_f, raise}, 2'b00);
        pulse(4);
        check("gate_after_otp", gate_cnt, 4);
        $display("test over-temperature done");
    endtask

    initial
    begin
        {req, clamp_req, lp, sb, ab, ov, cold, pwr, supply} = '0;
        ramp_limit = 8'hFF;
        miscompares = 0;
        n_compared = 0;
        gate_cnt = 0;
        rec_cnt = 0;
        rst_n = 1'b0;
        repeat (10) @(negedge ref_clk);
        check("in_reset", {gate, clamp, enable, ov_f, pwr_f, ot_f, raise, rec, start}, 0);
        rst_n = 1'b1;
        test_startup();
        test_clamp();
        test_ceiling();
        test_ov();
        test_power();
        test_otp();
        give_verdict();
    end

    initial
    begin
        #(20000 * 4);
        miscompares++;
        $display("Watchdog expired");
        give_verdict();
    end
endmodule
